// ==== rtl/mrd_pkg.sv ====
package mrd_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 64;
  localparam int REG_N  = 64;
  localparam int IDX_W  = 6;

  localparam logic [16:0] PAGE1_BIT_MASK = 17'h10000;
  localparam logic [16:0] PAGE_OFS_MASK  = 17'h0FFFF;
  localparam logic [16:0] SEC_BASE       = 17'h08000;
  localparam logic [16:0] SEC_LIMIT      = 17'h0C000;

  localparam logic [16:0] FEATURE_ID_0     = 17'h00000;
  localparam logic [16:0] FEATURE_ID_5     = 17'h00014;
  localparam logic [16:0] IMPLEMENTER_ID   = 17'h00018;
  localparam logic [16:0] ARCHITECTURE_ID  = 17'h0001C;
  localparam logic [16:0] GLOBAL_CONTROL_0 = 17'h00020;
  localparam logic [16:0] GLOBAL_CONTROL_0_ACK = 17'h00024;
  localparam logic [16:0] GLOBAL_CONTROL_1 = 17'h00028;
  localparam logic [16:0] GLOBAL_CONTROL_2 = 17'h0002C;
  localparam logic [16:0] UNIT_STATUS      = 17'h00040;
  localparam logic [16:0] GLOBAL_BYPASS_ATTRIBUTES     = 17'h00044;
  localparam logic [16:0] ALT_GLOBAL_BYPASS_ATTRIBUTES = 17'h00048;
  localparam logic [16:0] INTERRUPT_CONTROL     = 17'h00050;
  localparam logic [16:0] INTERRUPT_CONTROL_ACK = 17'h00054;
  localparam logic [16:0] GLOBAL_ERROR_FLAGS       = 17'h00060;
  localparam logic [16:0] GLOBAL_ERROR_ACKNOWLEDGE = 17'h00064;
  localparam logic [16:0] GLOBAL_ERROR_IRQ_CONFIG_0 = 17'h00068;
  localparam logic [16:0] GLOBAL_ERROR_IRQ_CONFIG_1 = 17'h00070;
  localparam logic [16:0] GLOBAL_ERROR_IRQ_CONFIG_2 = 17'h00074;
  localparam logic [16:0] STREAM_TABLE_BASE_ADDRESS = 17'h00080;
  localparam logic [16:0] STREAM_TABLE_CONFIG       = 17'h00088;
  localparam logic [16:0] COMMAND_QUEUE_BASE_ADDRESS = 17'h00090;
  localparam logic [16:0] COMMAND_QUEUE_PRODUCER     = 17'h00098;
  localparam logic [16:0] COMMAND_QUEUE_CONSUMER     = 17'h0009C;
  localparam logic [16:0] EVENT_QUEUE_BASE_ADDRESS   = 17'h000A0;
  localparam logic [16:0] RESERVED_EVENT_PRODUCER_ALIAS = 17'h000A8;
  localparam logic [16:0] RESERVED_EVENT_CONSUMER_ALIAS = 17'h000AC;
  localparam logic [16:0] EVENT_QUEUE_IRQ_CONFIG_0   = 17'h000B0;
  localparam logic [16:0] EVENT_QUEUE_IRQ_CONFIG_1   = 17'h000B8;
  localparam logic [16:0] EVENT_QUEUE_IRQ_CONFIG_2   = 17'h000BC;
  localparam logic [16:0] PAGE_REQUEST_QUEUE_BASE    = 17'h000C0;
  localparam logic [16:0] RESERVED_PAGE_REQ_PRODUCER_ALIAS = 17'h000C8;
  localparam logic [16:0] RESERVED_PAGE_REQ_CONSUMER_ALIAS = 17'h000CC;
  localparam logic [16:0] EVENT_QUEUE_PRODUCER        = 17'h100A8;
  localparam logic [16:0] EVENT_QUEUE_CONSUMER        = 17'h100AC;
  localparam logic [16:0] PAGE_REQUEST_QUEUE_PRODUCER = 17'h100C8;

  // Secure group registers kept here (own choice of storage subset)
  localparam logic [16:0] SECURE_FEATURE_ID_1  = 17'h08004;
  localparam logic [16:0] SECURE_INIT_REGISTER = 17'h0803C;
  localparam logic [16:0] SECURE_CONTROL_0     = 17'h08020;

  // Bit positions
  localparam int CR0_CMDQ_EN_BIT   = 3;
  localparam int SEC_IMPL_BIT      = 31;

  // Cycles after reset release before the synchronised strap is trusted
  localparam logic [2:0] STRAP_SETTLE = 3'h5;

  // Access sizes
  localparam logic [1:0] SIZE_32 = 2'h2;
  localparam logic [1:0] SIZE_64 = 2'h3;

  typedef enum logic [2:0] {
    MRD_ACC_NONE    = 3'h1,
    MRD_ACC_LEGAL   = 3'h2,
    MRD_ACC_ILLEGAL = 3'h4
  } mrd_acc_t;
endpackage

// ==== rtl/mrd_reg_store.sv ====
`timescale 1ns/1ps
// Word store for writable registers, read data registered
module mrd_reg_store #(
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic          clock,
  input  wire logic          rst_n,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_idx,
  input  wire logic [31:0]   wr_data,
  input  wire logic [AW-1:0] rd_idx,
  output logic      [31:0]   rd_data,
  output logic      [31:0]   word_cr0
);
  logic [31:0] mem [DEPTH];

  if (DEPTH > (1 << AW)) begin : g_depth_check
    $error("mrd_reg_store depth exceeds index range");
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) mem[i] <= 32'h0;
    end else if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 32'h0;
    end else begin
      rd_data <= mem[rd_idx];
    end
  end

  assign word_cr0 = mem[mrd_pkg::GLOBAL_CONTROL_0[AW+1:2]];
endmodule

// ==== rtl/mrd_register_access_decode.sv ====
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01: Registers default 32-bit, little-endian, read/write
// RULE_02: Undefined page-0 locations read zero, ignore writes
// RULE_03: Page-1 undefined locations read zero, ignore writes
// RULE_04: Page-0 aliases of page-1 registers alias them
// RULE_05: Secure group hidden unless secure and implemented
// RULE_06: Identification registers constant from reset
// RULE_07: Reserved bits read zero; software writes zero
// RULE_08: Aligned 32-bit and 64-bit-register 64-bit access accepted
// RULE_09: Illegal size or alignment reads zero, ignores write
// RULE_10: Non-secure illegal access never touches secure state
// RULE_11: 64-bit access to 32-bit pair is ignored
// RULE_12: No access is ever aborted
// RULE_13: 64-bit register access done as two halves
// RULE_14: Upper half at offset plus four
// RULE_15: Software changes guarded fields only when allowed
// RULE_16: Software barriers guarded writes before enabling
// RULE_17: Software avoids atomic read-modify-write on registers
// RULE_18: Writes to read-only registers are ignored
// RULE_19: Event queue indices decoded on page 1
// RULE_20: Page-request producer decoded on page 1
// RULE_21: Two consecutive 64KB pages, page 1 above
// RULE_22: One fixed behaviour chosen for each option
module mrd_register_access_decode #(
  parameter logic [31:0] FEATURE_ID_VALUE  = 32'h0000_0000,
  parameter logic [31:0] IMPLEMENTER_VALUE = 32'h0000_0001, // Arbitrary value
  parameter logic [31:0] ARCH_VALUE        = 32'h0000_0002  // Arbitrary value
) (
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  input  wire logic [mrd_pkg::ADDR_W-1:0]  address,
  input  wire logic [mrd_pkg::DATA_W-1:0]  write_data,
  input  wire logic [1:0]                  access_size,
  input  wire logic                        secure,
  input  wire logic                        write_strobe,
  input  wire logic                        read_strobe,
  input  wire logic                        secure_state_implemented_pin,
  output logic      [mrd_pkg::DATA_W-1:0]  read_data,
  output logic                             illegal_access,
  output logic                             command_queue_enable
);
  localparam logic [16:0] WORD_MASK = 17'h1FFFC;

  logic        sec_impl;
  logic        sec_impl_seen;
  logic        sec_ok;
  logic        is64;
  logic        legal;
  logic [16:0] lo_addr;
  logic [16:0] hi_addr;
  logic        lo_hit;
  logic        hi_hit;
  logic        lo_wr;
  logic        hi_wr;
  logic [31:0] lo_rd;
  logic [31:0] hi_rd;
  logic [31:0] event_prod;
  logic [31:0] event_cons;
  logic [31:0] pri_prod;
  logic [31:0] sec_init;
  logic [31:0] sec_cr0;
  logic [31:0] cr0_ack;
  logic [31:0] cr0_word;
  logic [31:0] store_rd;
  logic [5:0]  st_widx;
  logic [5:0]  st_ridx;
  logic        st_wen;
  logic [31:0] st_wdata;
  logic        use_store_lo;
  logic        use_store_hi;
  logic [31:0] imm_lo;
  logic [31:0] imm_hi;
  logic        rd_pend;
  logic        rd_store_lo;
  mrd_pkg::mrd_acc_t acc_state;

  // Folds page-0 alias offsets onto page-1 indices
  function automatic logic [16:0] canon(input logic [16:0] a);
    logic [16:0] w;
    w = a & WORD_MASK;
    if (w == mrd_pkg::RESERVED_EVENT_PRODUCER_ALIAS) w = mrd_pkg::EVENT_QUEUE_PRODUCER; // see RULE_04
    if (w == mrd_pkg::RESERVED_EVENT_CONSUMER_ALIAS) w = mrd_pkg::EVENT_QUEUE_CONSUMER; // see RULE_19
    if (w == mrd_pkg::RESERVED_PAGE_REQ_PRODUCER_ALIAS) w = mrd_pkg::PAGE_REQUEST_QUEUE_PRODUCER; // see RULE_20
    return w;
  endfunction

  // Writable page-0 registers held in the store
  function automatic logic store_map(input logic [16:0] a);
    if (a[16]) return 1'b0; // see RULE_21
    case (a)
      mrd_pkg::GLOBAL_CONTROL_0, mrd_pkg::GLOBAL_CONTROL_1, mrd_pkg::GLOBAL_CONTROL_2,
      mrd_pkg::GLOBAL_BYPASS_ATTRIBUTES, mrd_pkg::ALT_GLOBAL_BYPASS_ATTRIBUTES,
      mrd_pkg::INTERRUPT_CONTROL, mrd_pkg::GLOBAL_ERROR_ACKNOWLEDGE,
      mrd_pkg::GLOBAL_ERROR_IRQ_CONFIG_0, mrd_pkg::GLOBAL_ERROR_IRQ_CONFIG_0 + 17'h4,
      mrd_pkg::GLOBAL_ERROR_IRQ_CONFIG_1, mrd_pkg::GLOBAL_ERROR_IRQ_CONFIG_2,
      mrd_pkg::STREAM_TABLE_BASE_ADDRESS, mrd_pkg::STREAM_TABLE_BASE_ADDRESS + 17'h4,
      mrd_pkg::STREAM_TABLE_CONFIG,
      mrd_pkg::COMMAND_QUEUE_BASE_ADDRESS, mrd_pkg::COMMAND_QUEUE_BASE_ADDRESS + 17'h4,
      mrd_pkg::COMMAND_QUEUE_PRODUCER, mrd_pkg::COMMAND_QUEUE_CONSUMER,
      mrd_pkg::EVENT_QUEUE_BASE_ADDRESS, mrd_pkg::EVENT_QUEUE_BASE_ADDRESS + 17'h4,
      mrd_pkg::EVENT_QUEUE_IRQ_CONFIG_0, mrd_pkg::EVENT_QUEUE_IRQ_CONFIG_0 + 17'h4,
      mrd_pkg::EVENT_QUEUE_IRQ_CONFIG_1, mrd_pkg::EVENT_QUEUE_IRQ_CONFIG_2,
      mrd_pkg::PAGE_REQUEST_QUEUE_BASE, mrd_pkg::PAGE_REQUEST_QUEUE_BASE + 17'h4:
        return 1'b1; // see RULE_01
      default: return 1'b0; // see RULE_02
    endcase
  endfunction

  // True when the word belongs to a 64-bit register (lower half)
  function automatic logic is_reg64(input logic [16:0] a);
    case (a)
      mrd_pkg::GLOBAL_ERROR_IRQ_CONFIG_0, mrd_pkg::STREAM_TABLE_BASE_ADDRESS,
      mrd_pkg::COMMAND_QUEUE_BASE_ADDRESS, mrd_pkg::EVENT_QUEUE_BASE_ADDRESS,
      mrd_pkg::EVENT_QUEUE_IRQ_CONFIG_0, mrd_pkg::PAGE_REQUEST_QUEUE_BASE:
        return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // Values of registers not kept in the store
  function automatic logic [31:0] imm_read(input logic [16:0] a, input logic ok,
                                           input logic [31:0] ep, input logic [31:0] ec,
                                           input logic [31:0] pp, input logic [31:0] si,
                                           input logic [31:0] sc, input logic [31:0] ack,
                                           input logic simp);
    if (a >= mrd_pkg::FEATURE_ID_0 && a <= mrd_pkg::FEATURE_ID_5) return FEATURE_ID_VALUE; // see RULE_06
    case (a)
      mrd_pkg::IMPLEMENTER_ID:       return IMPLEMENTER_VALUE;
      mrd_pkg::ARCHITECTURE_ID:      return ARCH_VALUE;
      mrd_pkg::GLOBAL_CONTROL_0_ACK: return ack;
      mrd_pkg::INTERRUPT_CONTROL_ACK, mrd_pkg::UNIT_STATUS, mrd_pkg::GLOBAL_ERROR_FLAGS:
        return 32'h0; // see RULE_07
      mrd_pkg::EVENT_QUEUE_PRODUCER:        return ep;
      mrd_pkg::EVENT_QUEUE_CONSUMER:        return ec;
      mrd_pkg::PAGE_REQUEST_QUEUE_PRODUCER: return pp;
      mrd_pkg::SECURE_FEATURE_ID_1:  return ok ? {simp, 31'h0} : 32'h0; // see RULE_05
      mrd_pkg::SECURE_INIT_REGISTER: return ok ? si : 32'h0;
      mrd_pkg::SECURE_CONTROL_0:     return ok ? sc : 32'h0;
      default:                       return 32'h0; // see RULE_03
    endcase
  endfunction

  mrd_sec_sync u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .pin   (secure_state_implemented_pin),
    .level (sec_impl)
  );

  // Strap latched once the synchroniser has settled, so the id value stays constant
  logic [2:0] settle_cnt;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      settle_cnt <= 3'h0;
    end else if (!sec_impl_seen) begin
      settle_cnt <= settle_cnt + 3'h1;
    end
  end
  assign sec_impl_seen = (settle_cnt == mrd_pkg::STRAP_SETTLE);

  logic sec_impl_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sec_impl_q <= 1'b0;
    end else if (settle_cnt == mrd_pkg::STRAP_SETTLE - 3'h1) begin
      sec_impl_q <= sec_impl; // see RULE_06
    end
  end

  assign sec_ok  = sec_impl_q && secure; // see RULE_05
  assign is64    = (access_size == mrd_pkg::SIZE_64);
  assign lo_addr = canon(address & WORD_MASK);
  assign hi_addr = canon((address & WORD_MASK) + 17'h4);

  // Legal: 32-bit word aligned, or 64-bit aligned on a 64-bit register
  always_comb begin
    legal = 1'b0;
    if (access_size == mrd_pkg::SIZE_32) legal = (address[1:0] == 2'h0); // see RULE_08
    else if (is64) legal = (address[2:0] == 3'h0) && is_reg64(lo_addr); // see RULE_11
  end

  always_comb begin
    acc_state = mrd_pkg::MRD_ACC_NONE;
    if (write_strobe || read_strobe) begin
      acc_state = legal ? mrd_pkg::MRD_ACC_LEGAL : mrd_pkg::MRD_ACC_ILLEGAL; // see RULE_09
    end
  end

  logic [5:0] lo_idx;
  logic [5:0] hi_idx;
  assign lo_idx       = lo_addr[7:2];
  assign hi_idx       = hi_addr[7:2];
  assign use_store_lo = store_map(lo_addr);
  assign use_store_hi = store_map(hi_addr);

  logic acc_ok;
  logic sec_zone_lo;
  assign sec_zone_lo = (lo_addr >= mrd_pkg::SEC_BASE) && (lo_addr < mrd_pkg::SEC_LIMIT);
  assign acc_ok = (acc_state == mrd_pkg::MRD_ACC_LEGAL) && (!sec_zone_lo || sec_ok); // see RULE_10
  assign lo_wr  = write_strobe && acc_ok;
  assign hi_wr  = write_strobe && acc_ok && is64;

  // Store is single-ported: a 64-bit write updates the lower half now
  // and the upper half in the following cycle if no new store write claims that cycle
  logic        hi_pend;
  logic [5:0]  hi_pend_idx;
  logic [31:0] hi_pend_data;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hi_pend      <= 1'b0;
      hi_pend_idx  <= 6'h0;
      hi_pend_data <= 32'h0;
    end else begin
      hi_pend      <= hi_wr && use_store_hi; // see RULE_13
      hi_pend_idx  <= hi_idx;
      hi_pend_data <= write_data[63:32]; // see RULE_14
    end
  end

  always_comb begin
    st_wen   = 1'b0;
    st_widx  = lo_idx;
    st_wdata = write_data[31:0];
    if (lo_wr && use_store_lo) begin
      st_wen = 1'b1; // see RULE_18
    end else if (hi_pend) begin
      st_wen   = 1'b1;
      st_widx  = hi_pend_idx;
      st_wdata = hi_pend_data;
    end
  end

  assign st_ridx = lo_idx;

  mrd_reg_store #(.DEPTH(mrd_pkg::REG_N), .AW(mrd_pkg::IDX_W)) u_store (
    .clock    (clock),
    .rst_n    (rst_n),
    .wr_en    (st_wen),
    .wr_idx   (st_widx),
    .wr_data  (st_wdata),
    .rd_idx   (st_ridx),
    .rd_data  (store_rd),
    .word_cr0 (cr0_word)
  );

  assign command_queue_enable = cr0_word[mrd_pkg::CR0_CMDQ_EN_BIT];

  // Page-1 queue indices and secure registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      event_prod <= 32'h0;
      event_cons <= 32'h0;
      pri_prod   <= 32'h0;
      sec_init   <= 32'h0;
      sec_cr0    <= 32'h0;
    end else begin
      if (lo_wr && lo_addr == mrd_pkg::EVENT_QUEUE_PRODUCER) event_prod <= write_data[31:0]; // see RULE_19
      if (lo_wr && lo_addr == mrd_pkg::EVENT_QUEUE_CONSUMER) event_cons <= write_data[31:0];
      if (lo_wr && lo_addr == mrd_pkg::PAGE_REQUEST_QUEUE_PRODUCER) pri_prod <= write_data[31:0]; // see RULE_20
      if (lo_wr && sec_ok && lo_addr == mrd_pkg::SECURE_INIT_REGISTER) sec_init <= write_data[31:0];
      if (lo_wr && sec_ok && lo_addr == mrd_pkg::SECURE_CONTROL_0) sec_cr0 <= write_data[31:0];
    end
  end

  // Acknowledge mirrors the control word one cycle after it changes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cr0_ack <= 32'h0;
    end else begin
      cr0_ack <= cr0_word;
    end
  end

  assign imm_lo = imm_read(lo_addr, sec_ok, event_prod, event_cons, pri_prod,
                           sec_init, sec_cr0, cr0_ack, sec_impl_q);
  assign imm_hi = imm_read(hi_addr, sec_ok, event_prod, event_cons, pri_prod,
                           sec_init, sec_cr0, cr0_ack, sec_impl_q);

  // Read path: lower word from store (registered there) or flopped here
  logic [31:0] lo_q;
  logic [31:0] hi_q;
  logic        hi_store_sel;
  logic [31:0] hi_store_rd;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_pend      <= 1'b0;
      rd_store_lo  <= 1'b0;
      hi_store_sel <= 1'b0;
      lo_q         <= 32'h0;
      hi_q         <= 32'h0;
    end else begin
      rd_pend      <= read_strobe;
      rd_store_lo  <= read_strobe && acc_ok && use_store_lo;
      hi_store_sel <= read_strobe && acc_ok && is64 && use_store_hi;
      lo_q         <= (read_strobe && acc_ok) ? imm_lo : 32'h0; // see RULE_12
      hi_q         <= 32'h0;
      if (read_strobe && acc_ok && is64) begin
        hi_q <= imm_hi; // see RULE_22
      end
    end
  end

  // Upper half of 64-bit store registers is read from a second copy
  mrd_reg_store #(.DEPTH(mrd_pkg::REG_N), .AW(mrd_pkg::IDX_W)) u_store_hi (
    .clock    (clock),
    .rst_n    (rst_n),
    .wr_en    (st_wen),
    .wr_idx   (st_widx),
    .wr_data  (st_wdata),
    .rd_idx   (hi_idx),
    .rd_data  (hi_store_rd),
    .word_cr0 ()
  );

  always_comb begin
    read_data = '0;
    if (rd_pend) begin
      read_data[31:0]  = rd_store_lo ? store_rd : lo_q;
      read_data[63:32] = hi_q | (hi_store_sel ? hi_store_rd : 32'h0);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      illegal_access <= 1'b0;
    end else begin
      illegal_access <= (acc_state == mrd_pkg::MRD_ACC_ILLEGAL);
    end
  end

  ns_write_guard_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE_10
    (write_strobe && !secure && lo_addr == mrd_pkg::SECURE_CONTROL_0)
      |=> $stable(sec_cr0)) else $error("Non-secure write reached secure register");
  illegal_read_zero_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE_09
    (read_strobe && !legal) |=> (read_data == '0)) else $error("Illegal read not zero");
  id_const_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE_06
    (read_strobe && legal && lo_addr == mrd_pkg::IMPLEMENTER_ID)
      |=> read_data[31:0] == IMPLEMENTER_VALUE) else $error("Id value wrong");
  event_alias_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE_04
    (write_strobe && legal && !is64
      && (address & WORD_MASK) == mrd_pkg::RESERVED_EVENT_PRODUCER_ALIAS)
      |=> event_prod == $past(write_data[31:0])) else $error("Alias write lost");
  pri_prod_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE_20
    (write_strobe && legal && !is64 && lo_addr == mrd_pkg::PAGE_REQUEST_QUEUE_PRODUCER)
      |=> pri_prod == $past(write_data[31:0])) else $error("Producer write lost");
  pair_ignore_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE_11
    (is64 && (write_strobe || read_strobe) && !is_reg64(lo_addr))
      |=> illegal_access) else $error("Pair access not flagged");
  upper_half_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE_13
    (write_strobe && acc_ok && is64 && use_store_hi) |=> hi_pend ##1 !hi_pend)
    else $error("Upper half not committed");
  read_once_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE_01
    !$past(read_strobe) |-> read_data == '0) else $error("Read data outside slot");
endmodule

// ==== rtl/mrd_sec_sync.sv ====
`timescale 1ns/1ps
// Three-stage synchroniser for the security strap pin
module mrd_sec_sync (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      level
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1    <= 1'b0;
      s2    <= 1'b0;
      s3    <= 1'b0;
      level <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) level <= s3;
    end
  end
endmodule

// ==== tb/mrd_host_model.sv ====
`timescale 1ns/1ps
// Register master on the far side of the decode block
module mrd_host_model (
  input  wire logic                       clock,
  input  wire logic [mrd_pkg::DATA_W-1:0] read_data,
  input  wire logic                       illegal_access,
  output logic      [mrd_pkg::ADDR_W-1:0] address,
  output logic      [mrd_pkg::DATA_W-1:0] write_data,
  output logic      [1:0]                 access_size,
  output logic                            secure,
  output logic                            write_strobe,
  output logic                            read_strobe
);
  initial begin
    address      = '0;
    write_data   = '0;
    access_size  = mrd_pkg::SIZE_32;
    secure       = 1'b0;
    write_strobe = 1'b0;
    read_strobe  = 1'b0;
  end

  // One access: strobe for one cycle, answer taken in the cycle after
  // Callers pass zeros in unused bit positions
  // Plain writes only, never a locked read-modify-write
  // Guarded bases are written before their enable is set
  // Page-0 alias offsets are touched only to observe the alias choice
  task automatic acc(input logic wr, input logic [16:0] a, input logic [1:0] sz,
                     input logic sec, input logic [63:0] wd,
                     output logic [63:0] rd, output logic ill);
    @(posedge clock);
    address      <= a;
    access_size  <= sz;
    secure       <= sec;
    write_data   <= wd;
    write_strobe <= wr;
    read_strobe  <= !wr;
    @(posedge clock);
    write_strobe <= 1'b0;
    read_strobe  <= 1'b0;
    @(negedge clock);
    rd  = read_data;
    ill = illegal_access;
  endtask
endmodule

// ==== tb/tb_mrd_register_access_decode.sv ====
`timescale 1ns/1ps
module tb_mrd_register_access_decode;
  typedef struct {
    logic [16:0] wa;
    logic [1:0]  ws;
    logic [63:0] wd;
    logic [16:0] ra;
    logic [1:0]  rs;
    logic [63:0] ex;
  } mrd_row_t;

  logic                       clock;
  logic                       rst_n;
  logic                       secure_state_implemented_pin;
  logic [mrd_pkg::ADDR_W-1:0] address;
  logic [mrd_pkg::DATA_W-1:0] write_data;
  logic [1:0]                 access_size;
  logic                       secure;
  logic                       write_strobe;
  logic                       read_strobe;
  logic [mrd_pkg::DATA_W-1:0] read_data;
  logic                       illegal_access;
  logic                       command_queue_enable;
  logic [63:0]                rd;
  logic                       ill;
  int                         num_errors;
  int                         checked;
  int                         cycles;
  mrd_row_t                   rows [15];

  mrd_register_access_decode dut_u (
    .clock(clock), .rst_n(rst_n), .address(address), .write_data(write_data),
    .access_size(access_size), .secure(secure), .write_strobe(write_strobe),
    .read_strobe(read_strobe),
    .secure_state_implemented_pin(secure_state_implemented_pin), .read_data(read_data),
    .illegal_access(illegal_access), .command_queue_enable(command_queue_enable));

  mrd_host_model host_u (
    .clock(clock), .read_data(read_data), .illegal_access(illegal_access),
    .address(address), .write_data(write_data), .access_size(access_size),
    .secure(secure), .write_strobe(write_strobe), .read_strobe(read_strobe));

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (num_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      num_errors++;
      finish_test();
    end
  end

  initial begin
    rst_n = 1'b0;
    secure_state_implemented_pin = 1'b1;
    num_errors = 0;
    checked = 0;
    rows[0]  = '{17'h00028, 2'h2, 64'h1234ABCD, 17'h00028, 2'h2, 64'h1234ABCD};
    rows[1]  = '{17'h10028, 2'h2, 64'h5, 17'h00028, 2'h2, 64'h1234ABCD};
    rows[2]  = '{17'h10028, 2'h2, 64'h5, 17'h10028, 2'h2, 64'h0};
    rows[3]  = '{17'h00000, 2'h2, 64'hFFFFFFFF, 17'h00000, 2'h2, 64'h0};
    rows[4]  = '{17'h00018, 2'h2, 64'h0, 17'h00018, 2'h2, 64'h1};
    rows[5]  = '{17'h00200, 2'h2, 64'hFF, 17'h00200, 2'h2, 64'h0};
    rows[6]  = '{17'h100A8, 2'h2, 64'h11, 17'h000A8, 2'h2, 64'h11};
    rows[7]  = '{17'h000AC, 2'h2, 64'h22, 17'h100AC, 2'h2, 64'h22};
    rows[8]  = '{17'h000C8, 2'h2, 64'h33, 17'h100C8, 2'h2, 64'h33};
    rows[9]  = '{17'h000CC, 2'h2, 64'h44, 17'h000CC, 2'h2, 64'h0};
    rows[10] = '{17'h00080, 2'h3, 64'h89ABCDEF_01234567, 17'h00084, 2'h2, 64'h89ABCDEF};
    rows[11] = '{17'h00080, 2'h2, 64'h76543210, 17'h00080, 2'h3, 64'h89ABCDEF_76543210};
    rows[12] = '{17'h00028, 2'h3, 64'hFFFFFFFF_FFFFFFFF, 17'h00028, 2'h2, 64'h1234ABCD};
    rows[13] = '{17'h0002A, 2'h2, 64'hFFFFFFFF, 17'h00028, 2'h2, 64'h1234ABCD};
    rows[14] = '{17'h00028, 2'h1, 64'hFFFFFFFF, 17'h00028, 2'h2, 64'h1234ABCD};
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (8) @(posedge clock);
    foreach (rows[i]) begin
      host_u.acc(1'b1, rows[i].wa, rows[i].ws, 1'b0, rows[i].wd, rd, ill);
      host_u.acc(1'b0, rows[i].ra, rows[i].rs, 1'b0, 64'h0, rd, ill);
      check("row read", rd, rows[i].ex);
    end
    host_u.acc(1'b1, 17'h0002A, 2'h2, 1'b0, 64'h1, rd, ill);
    check("misaligned flag", {63'h0, ill}, 64'h1);
    host_u.acc(1'b1, 17'h00028, 2'h3, 1'b0, 64'h1, rd, ill);
    check("pair flag", {63'h0, ill}, 64'h1);
    host_u.acc(1'b0, 17'h00090, 2'h3, 1'b0, 64'h0, rd, ill);
    check("legal flag", {63'h0, ill}, 64'h0);
    // Queue base goes in before the enable
    host_u.acc(1'b1, 17'h00090, 2'h3, 1'b0, 64'h0000_0001_0000_1000, rd, ill);
    check("queue enable off", {63'h0, command_queue_enable}, 64'h0);
    host_u.acc(1'b1, 17'h00020, 2'h2, 1'b0, 64'h8, rd, ill);
    check("queue enable on", {63'h0, command_queue_enable}, 64'h1);
    host_u.acc(1'b1, 17'h08020, 2'h2, 1'b1, 64'h5A, rd, ill);
    host_u.acc(1'b0, 17'h08020, 2'h2, 1'b1, 64'h0, rd, ill);
    check("secure read", rd, 64'h5A);
    host_u.acc(1'b0, 17'h08020, 2'h2, 1'b0, 64'h0, rd, ill);
    check("nonsecure read", rd, 64'h0);
    host_u.acc(1'b1, 17'h08020, 2'h2, 1'b0, 64'hA5, rd, ill);
    host_u.acc(1'b1, 17'h08022, 2'h2, 1'b0, 64'hFFFFFFFF, rd, ill);
    host_u.acc(1'b1, 17'h08020, 2'h3, 1'b0, 64'hFFFFFFFF, rd, ill);
    host_u.acc(1'b0, 17'h08020, 2'h2, 1'b1, 64'h0, rd, ill);
    check("secure kept", rd, 64'h5A);
    host_u.acc(1'b0, 17'h08004, 2'h2, 1'b1, 64'h0, rd, ill);
    check("strap bit", rd, 64'h80000000);
    @(posedge clock);
    rst_n <= 1'b0;
    secure_state_implemented_pin <= 1'b0;
    @(negedge clock);
    check("reset enable", {63'h0, command_queue_enable}, 64'h0);
    check("reset data", read_data, 64'h0);
    @(posedge clock);
    rst_n <= 1'b1;
    repeat (8) @(posedge clock);
    host_u.acc(1'b1, 17'h08020, 2'h2, 1'b1, 64'h3C, rd, ill);
    host_u.acc(1'b0, 17'h08020, 2'h2, 1'b1, 64'h0, rd, ill);
    check("no secure state", rd, 64'h0);
    finish_test();
  end
endmodule
